// [hdl/dcw_top.sv]
// dcw_top: register window and topology probe registers of a debug component
`timescale 1ns/100ps
`default_nettype none
module dcw_top
  import dcw_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // register bus
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // functional core
  input  wire logic [NUM_PROBE-1:0] func_out,
  output logic      [NUM_PROBE-1:0] func_in,
  // inter-component link signals
  input  wire logic [NUM_PROBE-1:0] link_in,
  output logic      [NUM_PROBE-1:0] link_out,
  // status
  output logic                      probe_active
);

  // ---------------------------------------------------------------
  // bus phases and decode
  // ---------------------------------------------------------------
  dcw_top_s             st_r;
  dcw_top_s             st_nxt;
  dcw_sel_e             sel;
  logic                 setup;
  logic                 wr_acc;
  logic                 rd_acc;
  logic [1:0]           sub_idx;
  logic [31:0]          rd_word;
  logic [31:0]          mem_rdata;
  logic [NUM_PROBE-1:0] probe_smp;
  logic [WA_W-1:0]      wa;

  // only the word address inside the window is looked at; bits above are
  // left to the interconnect select and the byte lane bits never matter
  assign wa      = paddr[ADDR_HI:2];
  assign sel     = dcw_decode(wa);
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign sub_idx = paddr[3:2];

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && st_r.err;

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  // the bus port itself carries no probe registers; its place in the
  // system is known from the lookup table
  always_comb begin
    rd_word = RST_WORD;
    if (sel == SEL_INTEGRATION_MODE_CONTROL) begin
      rd_word[0] = st_r.integration_mode_enable;
    end else if (sel == SEL_TOPO) begin
      rd_word[0] = st_r.topo;
    end else if (sel == SEL_PIN) begin
      rd_word[NUM_PROBE-1:0] = probe_smp;
    end else if (sel == SEL_DRV) begin
      rd_word[0] = st_r.drv[sub_idx];
    end else if (sel == SEL_LBASE) begin
      rd_word = LINK_BASE;
    end else if (sel == SEL_PIDR4) begin
      rd_word[7:0] = {SIZE_LOG2, ID_CONT};
    end else if (sel == SEL_PID) begin
      rd_word[7:0] = id_byte(1'b0, sub_idx);
    end else if (sel == SEL_CID) begin
      rd_word[7:0] = id_byte(1'b1, sub_idx);
    end
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // read data and error are fixed at the setup edge and held
    if (setup) begin
      st_nxt.err     = (sel == SEL_NONE);
      st_nxt.sel_mem = (sel == SEL_MEM);
      st_nxt.rdata   = rd_word;
    end
    if (wr_acc) begin
      if (sel == SEL_INTEGRATION_MODE_CONTROL) begin
        st_nxt.integration_mode_enable = pwdata[0];
      end else if (sel == SEL_TOPO) begin
        st_nxt.topo = pwdata[0];
      end else if (sel == SEL_DRV) begin
        st_nxt.drv[sub_idx] = pwdata[0];
      end
    end
  end

  // functional mode out of reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r         <= '0;
      st_r.integration_mode_enable     <= RST_MODE;
      st_r.topo    <= RST_MODE;
      st_r.rdata   <= RST_WORD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // scratch words are fetched from their own register, so the final mux
  // only chooses between two flip-flop outputs
  assign prdata = st_r.sel_mem ? mem_rdata : st_r.rdata;

  // integration mode and the narrower probe mode both hand the link
  // pins to the registers
  assign probe_active = st_r.integration_mode_enable || st_r.topo;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  dcw_scratch_mem u_mem (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_en   (wr_acc && sel == SEL_MEM),
    .rd_en   (setup && sel == SEL_MEM),
    .addr    (paddr[MEM_AW+1:2]),
    .wdata   (pwdata),
    .rdata   (mem_rdata)
  );

  // outputs follow the core unless a probe mode is on
  dcw_probe_iso u_iso (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .probe_mode (probe_active),
    .probe_drv  (st_r.drv),
    .func_out   (func_out),
    .func_in    (func_in),
    .link_in    (link_in),
    .link_out   (link_out),
    .probe_smp  (probe_smp)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_SIZE_FIELD: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rd_acc && sel == SEL_PIDR4
      |-> prdata[7:4] == SIZE_LOG2 && prdata[7:4] != SIZE_RSVD)
    else $error("size field not reported correctly");

  AST_MGMT_LAST_BLOCK: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    psel && penable && wa[WA_W-1:10] != LAST_BLK && !st_r.sel_mem
      |-> pslverr && prdata == RST_WORD)
    else $error("management space answered outside last block");

  AST_LOW_BITS_IGNORED: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    setup ##1 (rd_acc && $stable(paddr[31:2]))
      |-> sel == dcw_decode({paddr[ADDR_HI:3], paddr[2]}))
    else $error("byte lane bits changed the decode");

  AST_MODE_ENABLE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_acc && sel == SEL_INTEGRATION_MODE_CONTROL && pwdata[0]
      |=> probe_active ##1 (link_out == $past(st_r.drv)))
    else $error("integration enable did not hand over outputs");

  AST_INTEGRATION_MODE_CONTROL_READ: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rd_acc && sel == SEL_INTEGRATION_MODE_CONTROL
      |-> prdata[31:1] == 31'h0000_0000 && prdata[0] == st_r.integration_mode_enable)
    else $error("integration control read back wrong");

  AST_DRIVE_ALONE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    wr_acc && sel == SEL_DRV
      |=> ((st_r.drv ^ $past(st_r.drv))
           & ~(4'b0001 << $past(sub_idx))) == 4'h0
          && st_r.drv[$past(sub_idx)] == $past(pwdata[0]))
    else $error("probe drive write disturbed another output");

  AST_DRIVE_OUT: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    probe_active |=> link_out == $past(st_r.drv))
    else $error("probe value not on link output");

  AST_FUNC_OUT: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !probe_active |=> link_out == $past(func_out))
    else $error("link output not functional outside probe mode");

  AST_ISOLATE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    probe_active [*2] |-> func_in == 4'h0)
    else $error("core not isolated while probing");

  AST_INPUT_READ: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    setup && sel == SEL_PIN ##1 rd_acc
      |-> prdata[NUM_PROBE-1:0] == $past(probe_smp)
          && prdata[31:NUM_PROBE] == 28'h000_0000)
    else $error("probe input read wrong");

  AST_INPUT_SAMPLE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> probe_smp == $past(link_in))
    else $error("link input not sampled");

  AST_LINK_BASE: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rd_acc && sel == SEL_LBASE && !st_r.err |-> prdata == LINK_BASE)
    else $error("linked region base read wrong");

  AST_MEM_WINDOW: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    psel && penable && wa[WA_W-1:10] == MEM_BLK
      && {wa[9:0], 2'b00} < MEM_BYTES |-> !pslverr)
    else $error("first block words refused");

  AST_CLASS_ONLY_ID: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    COMP_CLASS == CLASS_UNREL && setup
      |-> sel inside {SEL_NONE, SEL_MEM, SEL_ZERO, SEL_PIDR4, SEL_PID, SEL_CID})
    else $error("unrelated class decoded a non-identification register");

endmodule : dcw_top
`default_nettype wire

// [hdl/dcw_pkg.sv]
// dcw_pkg: constants, types and decode helpers for the debug component window
package dcw_pkg;
  // ---------------------------------------------------------------
  // window geometry
  // ---------------------------------------------------------------
  // fixed at two 4KB blocks: block 0 holds scratch words, block 1 the
  // management registers
  localparam logic [3:0] SIZE_LOG2 = 4'h1;
  localparam logic [3:0] SIZE_RSVD = 4'hF;
  localparam int         BLK_W     = int'(SIZE_LOG2);
  localparam int         ADDR_HI   = 11 + BLK_W;
  localparam int         WA_W      = ADDR_HI - 1;
  localparam logic [BLK_W-1:0] LAST_BLK = '1;
  localparam logic [BLK_W-1:0] MEM_BLK  = '0;

  // ---------------------------------------------------------------
  // byte offsets inside a 4KB block
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_DRV0   = 12'h0EE0;
  localparam logic [11:0] OFS_LBASE  = 12'h0EF0;
  localparam logic [11:0] OFS_TOPO   = 12'h0EF4;
  localparam logic [11:0] OFS_PIN    = 12'h0EF8;
  localparam logic [11:0] OFS_INTEGRATION_MODE_CONTROL = 12'h0F00;
  localparam logic [11:0] OFS_PIDR4  = 12'h0FD0;
  localparam logic [11:0] OFS_PIDR5  = 12'h0FD4;
  localparam logic [11:0] OFS_PIDR7  = 12'h0FDC;
  localparam logic [11:0] OFS_PID0   = 12'h0FE0;
  localparam logic [11:0] OFS_CID0   = 12'h0FF0;
  localparam logic [11:0] MEM_BYTES  = 12'h0040;

  // ---------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------
  localparam int          NUM_PROBE = 4;
  localparam int          MEM_DEPTH = 16;
  localparam int          MEM_AW    = 4;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic        RST_MODE  = 1'b0;
  // linked region base; zero means no linked region exists
  localparam logic [31:0] LINK_BASE = 32'h0000_0000;

  // ---------------------------------------------------------------
  // identification (all values arbitrary)
  // ---------------------------------------------------------------
  localparam logic [11:0] ID_PART  = 12'h0A5C;
  localparam logic [6:0]  ID_DSGN  = 7'h2B;
  localparam logic [3:0]  ID_CONT  = 4'h0;
  localparam logic [3:0]  ID_REV   = 4'h1;
  localparam logic [3:0]  COMP_CLASS  = 4'h9;
  localparam logic [3:0]  CLASS_UNREL = 4'hF;
  localparam logic [7:0]  PRE0 = 8'h0D;
  localparam logic [3:0]  PRE1 = 4'h0;
  localparam logic [7:0]  PRE2 = 8'h05;
  localparam logic [7:0]  PRE3 = 8'hB1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_NONE, SEL_MEM, SEL_ZERO, SEL_PIDR4, SEL_PID, SEL_CID,
    SEL_INTEGRATION_MODE_CONTROL, SEL_TOPO, SEL_PIN, SEL_DRV, SEL_LBASE
  } dcw_sel_e;

  typedef struct packed {
    logic                 integration_mode_enable;
    logic                 topo;
    logic [NUM_PROBE-1:0] drv;
    logic [31:0]          rdata;
    logic                 err;
    logic                 sel_mem;
  } dcw_top_s;

  typedef struct packed {
    logic [NUM_PROBE-1:0] link_out;
    logic [NUM_PROBE-1:0] func_in;
    logic [NUM_PROBE-1:0] smp;
  } dcw_iso_s;

  typedef struct packed {
    logic [MEM_DEPTH-1:0][31:0] word;
    logic [31:0]                rdata;
  } dcw_mem_s;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic dcw_sel_e dcw_decode(input logic [WA_W-1:0] wa);
    logic [BLK_W-1:0] blk;
    logic [11:0]      ofs;
    blk = wa[WA_W-1:10];
    ofs = {wa[9:0], 2'b00};
    if (blk == MEM_BLK && ofs < MEM_BYTES) dcw_decode = SEL_MEM;
    else if (blk != LAST_BLK) dcw_decode = SEL_NONE;
    else if (ofs == OFS_PIDR4) dcw_decode = SEL_PIDR4;
    else if (ofs[11:4] == OFS_PID0[11:4]) dcw_decode = SEL_PID;
    else if (ofs[11:4] == OFS_CID0[11:4]) dcw_decode = SEL_CID;
    else if (ofs >= OFS_PIDR5 && ofs <= OFS_PIDR7) dcw_decode = SEL_ZERO;
    else if (COMP_CLASS == CLASS_UNREL) dcw_decode = SEL_NONE;
    else if (ofs == OFS_INTEGRATION_MODE_CONTROL) dcw_decode = SEL_INTEGRATION_MODE_CONTROL;
    else if (ofs == OFS_TOPO) dcw_decode = SEL_TOPO;
    else if (ofs == OFS_PIN) dcw_decode = SEL_PIN;
    else if (ofs == OFS_LBASE) dcw_decode = SEL_LBASE;
    else if (ofs[11:4] == OFS_DRV0[11:4]) dcw_decode = SEL_DRV;
    else dcw_decode = SEL_NONE;
  endfunction : dcw_decode

  function automatic logic [7:0] id_byte(input logic cid, input logic [1:0] idx);
    if (cid) begin
      if (idx == 2'd0) id_byte = PRE0;
      else if (idx == 2'd1) id_byte = {COMP_CLASS, PRE1};
      else if (idx == 2'd2) id_byte = PRE2;
      else id_byte = PRE3;
    end else begin
      if (idx == 2'd0) id_byte = ID_PART[7:0];
      else if (idx == 2'd1) id_byte = {ID_DSGN[3:0], ID_PART[11:8]};
      else if (idx == 2'd2) id_byte = {ID_REV, 1'b1, ID_DSGN[6:4]};
      else id_byte = 8'h00;
    end
  endfunction : id_byte
endpackage : dcw_pkg

// [hdl/dcw_scratch_mem.sv]
// dcw_scratch_mem: component-specific scratch words in the first block
`timescale 1ns/100ps
`default_nettype none
module dcw_scratch_mem
  import dcw_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // access
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [MEM_AW-1:0] addr,
  input  wire logic [31:0]       wdata,
  output logic      [31:0]       rdata
);
  dcw_mem_s st_r;
  dcw_mem_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_en) st_nxt.word[addr] = wdata;
    if (rd_en) st_nxt.rdata = st_r.word[addr];
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign rdata = st_r.rdata;
endmodule : dcw_scratch_mem
`default_nettype wire

// [hdl/dcw_probe_iso.sv]
// dcw_probe_iso: isolation of link signals between functional and probe mode
`timescale 1ns/100ps
`default_nettype none
module dcw_probe_iso
  import dcw_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // mode and probe drive values
  input  wire logic                 probe_mode,
  input  wire logic [NUM_PROBE-1:0] probe_drv,
  // functional core side
  input  wire logic [NUM_PROBE-1:0] func_out,
  output logic      [NUM_PROBE-1:0] func_in,
  // link side
  input  wire logic [NUM_PROBE-1:0] link_in,
  output logic      [NUM_PROBE-1:0] link_out,
  output logic      [NUM_PROBE-1:0] probe_smp
);
  dcw_iso_s st_r;
  dcw_iso_s st_nxt;

  // the core sees zeros while probing so toggling links cannot upset it
  always_comb begin
    st_nxt.link_out = probe_mode ? probe_drv : func_out;
    st_nxt.func_in  = probe_mode ? '0 : link_in;
    st_nxt.smp      = link_in;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign link_out  = st_r.link_out;
  assign func_in   = st_r.func_in;
  assign probe_smp = st_r.smp;
endmodule : dcw_probe_iso
`default_nettype wire

// [verification/dcw_nbr_model.sv]
// dcw_nbr_model: neighbouring debug components seen across the link signals
`timescale 1ns/100ps
`default_nettype none
module dcw_nbr_model
  import dcw_pkg::*;
(
  // link signals of the component under test
  input  wire logic [NUM_PROBE-1:0] link_out,
  output logic      [NUM_PROBE-1:0] link_in,
  // bench control of the answer pattern
  input  wire logic [NUM_PROBE-1:0] flip
);
  // each neighbour answers on the next lane, so a swapped or stuck lane shows up
  assign link_in = {link_out[0], link_out[NUM_PROBE-1:1]} ^ flip;
endmodule : dcw_nbr_model
`default_nettype wire

// [verification/tb_dcw_top.sv]
// tb_dcw_top: register-level bench of the debug component window
`timescale 1ns/100ps
`default_nettype none
module tb_dcw_top
  import dcw_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                 clk_sys = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [31:0]          paddr = 32'h0000_0000;
  logic [31:0]          pwdata = 32'h0000_0000;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [NUM_PROBE-1:0] func_out = 4'h5;
  logic [NUM_PROBE-1:0] func_in;
  logic [NUM_PROBE-1:0] link_in;
  logic [NUM_PROBE-1:0] link_out;
  logic [NUM_PROBE-1:0] flip = 4'h0;
  logic                 probe_active;
  int                   error_cnt = 0;
  int                   cmp_count = 0;

  always #25 clk_sys = ~clk_sys;

  dcw_top dcw_top_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .func_out(func_out), .func_in(func_in),
    .link_in(link_in), .link_out(link_out), .probe_active(probe_active)
  );

  dcw_nbr_model dcw_nbr_model_i (.link_out(link_out), .link_in(link_in), .flip(flip));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] ra(input logic [11:0] ofs);
    ra = {20'h0_0001, ofs};
  endfunction : ra

  function automatic logic [31:0] nbr(input logic [3:0] lo, input logic [3:0] f);
    nbr = {28'h0, {lo[0], lo[3:1]} ^ f};
  endfunction : nbr

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one transfer; starts on the next rising edge, waits for pready without a cycle count
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("pslverr on write", {31'h0, eerr}, {31'h0, e});
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", exp, r);
    chk("pslverr on read", {31'h0, eerr}, {31'h0, e});
  endtask : rd

  // lets a register write reach the pins, then samples away from the edge
  task automatic pins(input logic [3:0] lo, input logic [3:0] fi, input logic act);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("link_out", {28'h0, lo}, {28'h0, link_out});
    chk("func_in", {28'h0, fi}, {28'h0, func_in});
    chk("probe_active", {31'h0, act}, {31'h0, probe_active});
  endtask : pins

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // reset state: functional mode, pins follow the core
    pins(4'h5, nbr(4'h5, 4'h0), 1'b0);
    rd(ra(OFS_INTEGRATION_MODE_CONTROL), 32'h0000_0000, 1'b0);
    $display("test reset done");

    // window map: two blocks, management block last
    rd(ra(OFS_PIDR4), 32'h0000_0010, 1'b0);
    rd(ra(OFS_PIDR5), 32'h0000_0000, 1'b0);
    rd({20'h0_0000, OFS_PIDR4}, 32'h0000_0000, 1'b1);
    rd(32'h0000_0800, 32'h0000_0000, 1'b1);
    rd({20'h0_0000, MEM_BYTES}, 32'h0000_0000, 1'b1);
    rd(ra(OFS_LBASE), LINK_BASE, 1'b0);
    for (int i = 0; i < MEM_DEPTH; i++) wr(4 * i, 32'h0101_0101 * i, 1'b0);
    for (int i = 0; i < MEM_DEPTH; i++) rd(4 * i, 32'h0101_0101 * i, 1'b0);
    wr(32'h0000_0800, 32'hFFFF_FFFF, 1'b1);
    wr(32'h0000_003C, 32'hA5A5_5A5A, 1'b0);
    rd(32'h0000_203E, 32'hA5A5_5A5A, 1'b0);
    $display("test window done");

    // drive values are stored but kept off the pins in functional mode
    wr(ra(OFS_DRV0), 32'h0000_0001, 1'b0);
    wr(ra(OFS_DRV0 + 12'h004), 32'h0000_0000, 1'b0);
    wr(ra(OFS_DRV0 + 12'h008), 32'h0000_0001, 1'b0);
    wr(ra(OFS_DRV0 + 12'h00C), 32'h0000_0001, 1'b0);
    func_out <= 4'hA;
    pins(4'hA, nbr(4'hA, 4'h0), 1'b0);
    rd(ra(OFS_DRV0 + 12'h008), 32'h0000_0001, 1'b0);
    rd(ra(OFS_PIN), nbr(4'hA, 4'h0), 1'b0);
    $display("test functional done");

    // integration mode takes over the pins; reserved bits read zero
    wr(ra(OFS_INTEGRATION_MODE_CONTROL), 32'hFFFF_FFFF, 1'b0);
    rd(ra(OFS_INTEGRATION_MODE_CONTROL), 32'h0000_0001, 1'b0);
    pins(4'hD, 4'h0, 1'b1);
    wr(ra(OFS_DRV0 + 12'h004), 32'h0000_0001, 1'b0);
    pins(4'hF, 4'h0, 1'b1);
    @(posedge clk_sys);
    flip <= 4'h6;
    rd(ra(OFS_PIN), nbr(4'hF, 4'h6), 1'b0);
    wr(ra(OFS_DRV0 + 12'h00C), 32'h0000_0000, 1'b0);
    pins(4'h7, 4'h0, 1'b1);
    rd(ra(OFS_PIN), nbr(4'h7, 4'h6), 1'b0);
    $display("test integration done");

    // topology-only mode isolates just the same, then back to functional
    wr(ra(OFS_INTEGRATION_MODE_CONTROL), 32'h0000_0000, 1'b0);
    pins(4'hA, nbr(4'hA, 4'h6), 1'b0);
    wr(ra(OFS_TOPO), 32'h0000_0001, 1'b0);
    rd(ra(OFS_TOPO), 32'h0000_0001, 1'b0);
    pins(4'h7, 4'h0, 1'b1);
    wr(ra(OFS_TOPO), 32'h0000_0000, 1'b0);
    pins(4'hA, nbr(4'hA, 4'h6), 1'b0);
    $display("test topology done");
    test_done();
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #(50 * 3000);
    error_cnt++;
    $display("[FAIL] watchdog expected done seen hang");
    test_done();
  end
endmodule : tb_dcw_top
`default_nettype wire
